/* rtl/wct_pkg.sv */
// shared constants of the word convert, test and shift unit
package wct_pkg;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] ADDR_OFS = 12'h004;
  localparam logic [11:0] OPER_OFS = 12'h008;
  localparam logic [11:0] STAT_OFS = 12'h00C;
  localparam logic [11:0] ISTAT_OFS = 12'h010;
  localparam logic [11:0] ICLR_OFS = 12'h014;
  localparam logic [11:0] IEN_OFS = 12'h018;
  localparam logic [2:0] TBL_PAGE = 3'h1;
  localparam int CTRL_RUNG_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_IDX_BIT = 4;
  localparam int CTRL_ECLR_BIT = 5;
  localparam int CTRL_CNT_LSB = 8;
  localparam int ADDR_DST_LSB = 16;
  localparam int OPER_B_LSB = 16;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam logic [6:0] HTOT_MAX = 7'h20;
  localparam logic [6:0] TTOH_MAX = 7'h40;
  localparam logic [7:0] CHR_ZERO = 8'h30;
  localparam logic [7:0] CHR_NINE = 8'h39;
  localparam logic [7:0] CHR_A = 8'h41;
  localparam logic [7:0] CHR_F = 8'h46;
  localparam logic [7:0] CHR_A_OFS = 8'h37;
  typedef enum logic [2:0] {
    hex_to_text_op = 3'h0,
    text_to_hex_op = 3'h1,
    bit_test_op = 3'h2,
    shift_right_one_op = 3'h3,
    shift_left_one_op = 3'h4
  } wct_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_CONV = 2'b11
  } wct_state_t;
endpackage : wct_pkg

/* rtl/wct_unit.sv */
// word convert, bit test and one-bit shift datapath with apb register access
// What this block does
// - rung on: hex-to-text turns each digit of n words into bytes, n 1..32
// - top digit of first source goes to low byte of first destination
// - hex-to-text with indexed source allows only n of one, else boundary error
// - rung on: text-to-hex packs bytes of n words into digits, n 1..64
// - low byte of first source becomes top digit of first destination
// - only codes for 0..9 and A..F are accepted as source bytes
// - illegal character: nothing written, rung output off, error flag set
// - text-to-hex with indexed source allows only n of one
// - bit test ands source with test word; output on when nonzero
// - right shift inserts zero at msb, bit shifted out goes to carry
// - after right shift, output on exactly when result lsb is one
// - left shift inserts zero at lsb, bit shifted out goes to carry
// - after left shift, output on exactly when result msb is one
`timescale 1ns/100ps
`default_nettype none
module wct_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rung_out,
  output logic carry_flag,
  output logic error_flag,
  output logic irq
);
  logic [15:0] tbl [0:127];
  logic rung_in_r;
  wct_pkg::wct_op_t op_r;
  logic indexed_r;
  logic [6:0] count_r;
  logic [6:0] src_r;
  logic [6:0] dst_r;
  logic [15:0] opa_r;
  logic [15:0] opb_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_en_r;
  wct_pkg::wct_state_t state_r;
  logic [6:0] idx_r;
  logic busy;
  logic wr;
  logic tbl_sel;
  logic reg_sel;
  logic ctrl_wr;
  logic start;
  logic start_ok;
  logic start_bad;
  logic is_conv;
  logic legal;
  logic [6:0] last;
  logic [15:0] chk_word;
  logic chk_bad;
  logic [15:0] h_word;
  logic [15:0] lo_word;
  logic [15:0] hi_word;
  logic hi_ok;
  logic [15:0] conv_word;
  logic conv_end;
  logic ev_done;
  logic ev_err;
  wct_pkg::wct_op_t new_op;
  logic [6:0] new_cnt;
  logic new_idx;

  function automatic logic [7:0] to_chr(input logic [3:0] d);
    if (d < 4'hA)
      to_chr = wct_pkg::CHR_ZERO + {4'h0, d};
    else
      to_chr = wct_pkg::CHR_A_OFS + {4'h0, d};
  endfunction : to_chr

  function automatic logic chr_ok(input logic [7:0] c);
    chr_ok = (c >= wct_pkg::CHR_ZERO && c <= wct_pkg::CHR_NINE) || (c >= wct_pkg::CHR_A && c <= wct_pkg::CHR_F);
  endfunction : chr_ok

  function automatic logic [3:0] to_dig(input logic [7:0] c);
    logic [7:0] v;
    v = (c <= wct_pkg::CHR_NINE) ? c - wct_pkg::CHR_ZERO : c - wct_pkg::CHR_A_OFS;
    to_dig = v[3:0];
  endfunction : to_dig

  // bus decode; the slave never stalls
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign tbl_sel = (paddr[11:9] == wct_pkg::TBL_PAGE) && (paddr[1:0] == 2'b00);
  assign reg_sel = paddr == wct_pkg::CTRL_OFS || paddr == wct_pkg::ADDR_OFS || paddr == wct_pkg::OPER_OFS
    || paddr == wct_pkg::STAT_OFS || paddr == wct_pkg::ISTAT_OFS || paddr == wct_pkg::ICLR_OFS
    || paddr == wct_pkg::IEN_OFS;
  assign pslverr = psel && penable && !(tbl_sel || reg_sel);
  assign busy = state_r != wct_pkg::ST_IDLE;
  // a control write while busy is dropped, except its error-clear bit, so a running conversion stays coherent
  assign ctrl_wr = wr && paddr == wct_pkg::CTRL_OFS && !busy;
  assign new_op = wct_pkg::wct_op_t'(pwdata[wct_pkg::CTRL_OP_LSB +: 3]);
  assign new_cnt = pwdata[wct_pkg::CTRL_CNT_LSB +: 7];
  assign new_idx = pwdata[wct_pkg::CTRL_IDX_BIT];
  assign start = ctrl_wr && pwdata[wct_pkg::CTRL_RUNG_BIT];
  assign is_conv = new_op == wct_pkg::hex_to_text_op || new_op == wct_pkg::text_to_hex_op;

  always_comb
  begin
    case (new_op)
      wct_pkg::hex_to_text_op:
        legal = new_cnt != 7'h00 && new_cnt <= wct_pkg::HTOT_MAX && !(new_idx && new_cnt != 7'h01);
      wct_pkg::text_to_hex_op:
        legal = new_cnt != 7'h00 && new_cnt <= wct_pkg::TTOH_MAX && !(new_idx && new_cnt != 7'h01);
      wct_pkg::bit_test_op, wct_pkg::shift_right_one_op, wct_pkg::shift_left_one_op:
        legal = 1'b1;
      default:
        legal = 1'b0;
    endcase
  end

  assign start_ok = start && legal;
  assign start_bad = start && !legal;

  // last destination index: two text words per source word, or one packed word per two sources
  assign last = (op_r == wct_pkg::hex_to_text_op) ? 7'({count_r[5:0], 1'b0} - 7'h01)
    : 7'(((count_r + 7'h01) >> 1) - 7'h01);
  assign chk_word = tbl[7'(src_r + idx_r)];
  assign chk_bad = !chr_ok(chk_word[7:0]) || !chr_ok(chk_word[15:8]);
  assign h_word = tbl[7'(src_r + {1'b0, idx_r[6:1]})];
  assign lo_word = tbl[7'(src_r + {idx_r[5:0], 1'b0})];
  assign hi_word = tbl[7'(src_r + {idx_r[5:0], 1'b1})];
  // odd count: the missing half is zero filled, callers must not rely on it
  assign hi_ok = 7'({idx_r[5:0], 1'b1}) < count_r;

  always_comb
  begin
    if (op_r == wct_pkg::hex_to_text_op)
    begin
      if (!idx_r[0])
        conv_word = {to_chr(h_word[11:8]), to_chr(h_word[15:12])};
      else
        conv_word = {to_chr(h_word[3:0]), to_chr(h_word[7:4])};
    end
    else
    begin
      conv_word = {to_dig(lo_word[7:0]), to_dig(lo_word[15:8]), 8'h00};
      if (hi_ok)
        conv_word[7:0] = {to_dig(hi_word[7:0]), to_dig(hi_word[15:8])};
    end
  end

  assign conv_end = state_r == wct_pkg::ST_CONV && idx_r == last;
  assign ev_done = (start_ok && !is_conv) || conv_end;
  assign ev_err = start_bad || (state_r == wct_pkg::ST_CHECK && chk_bad);

  // sequencer: text-to-hex scans every source word before writing any
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= wct_pkg::ST_IDLE;
      idx_r <= 7'h00;
    end
    else
    begin
      case (state_r)
        wct_pkg::ST_IDLE:
        begin
          idx_r <= 7'h00;
          if (start_ok && is_conv)
            state_r <= (new_op == wct_pkg::text_to_hex_op) ? wct_pkg::ST_CHECK : wct_pkg::ST_CONV;
        end
        wct_pkg::ST_CHECK:
        begin
          if (chk_bad)
            state_r <= wct_pkg::ST_IDLE;
          else if (idx_r == 7'(count_r - 7'h01))
          begin
            state_r <= wct_pkg::ST_CONV;
            idx_r <= 7'h00;
          end
          else
            idx_r <= idx_r + 7'h01;
        end
        wct_pkg::ST_CONV:
        begin
          if (conv_end)
            state_r <= wct_pkg::ST_IDLE;
          else
            idx_r <= idx_r + 7'h01;
        end
        default:
          state_r <= wct_pkg::ST_IDLE;
      endcase
    end
  end

  // word table, shared by software and the converter
  always_ff @(posedge mclk)
  begin
    if (state_r == wct_pkg::ST_CONV)
      tbl[7'(dst_r + idx_r)] <= conv_word;
    else if (wr && tbl_sel && !busy)
      tbl[paddr[8:2]] <= pwdata[15:0];
  end

  // control and operand registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rung_in_r <= 1'b0;
      op_r <= wct_pkg::hex_to_text_op;
      indexed_r <= 1'b0;
      count_r <= 7'h01;
      src_r <= 7'h00;
      dst_r <= 7'h00;
      opb_r <= 16'h0000;
    end
    else
    begin
      if (ctrl_wr)
      begin
        rung_in_r <= pwdata[wct_pkg::CTRL_RUNG_BIT];
        op_r <= new_op;
        indexed_r <= new_idx;
        count_r <= new_cnt;
      end
      if (wr && paddr == wct_pkg::ADDR_OFS && !busy)
      begin
        src_r <= pwdata[6:0];
        dst_r <= pwdata[wct_pkg::ADDR_DST_LSB +: 7];
      end
      if (wr && paddr == wct_pkg::OPER_OFS)
        opb_r <= pwdata[wct_pkg::OPER_B_LSB +: 16];
    end
  end

  // operand a, shifted in place
  always_ff @(posedge mclk)
  begin
    if (rst)
      opa_r <= 16'h0000;
    else if (start_ok && new_op == wct_pkg::shift_right_one_op)
      opa_r <= {1'b0, opa_r[15:1]};
    else if (start_ok && new_op == wct_pkg::shift_left_one_op)
      opa_r <= {opa_r[14:0], 1'b0};
    else if (wr && paddr == wct_pkg::OPER_OFS)
      opa_r <= pwdata[15:0];
  end

  // rung output and flags; a rung-off write only forces the output off
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rung_out <= 1'b0;
      carry_flag <= 1'b0;
    end
    else if (ctrl_wr && !pwdata[wct_pkg::CTRL_RUNG_BIT])
      rung_out <= 1'b0;
    else if (start_bad)
      rung_out <= 1'b0;
    else if (start_ok)
    begin
      case (new_op)
        wct_pkg::bit_test_op:
          rung_out <= |(opa_r & opb_r);
        wct_pkg::shift_right_one_op:
        begin
          rung_out <= opa_r[1];
          carry_flag <= opa_r[0];
        end
        wct_pkg::shift_left_one_op:
        begin
          rung_out <= opa_r[14];
          carry_flag <= opa_r[15];
        end
        default:
          rung_out <= 1'b0;
      endcase
    end
    else if (conv_end)
      rung_out <= 1'b1;
    else if (ev_err)
      rung_out <= 1'b0;
  end

  // sticky error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      error_flag <= 1'b0;
    else if (ev_err)
      error_flag <= 1'b1;
    else if (wr && paddr == wct_pkg::CTRL_OFS && pwdata[wct_pkg::CTRL_ECLR_BIT])
      error_flag <= 1'b0;
  end

  // interrupt status, enable and write-one clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_stat_r <= 2'b00;
      irq_en_r <= 2'b00;
    end
    else
    begin
      if (wr && paddr == wct_pkg::IEN_OFS)
        irq_en_r <= pwdata[1:0];
      irq_stat_r <= (irq_stat_r & ~((wr && paddr == wct_pkg::ICLR_OFS) ? pwdata[1:0] : 2'b00))
        | {ev_err, ev_done};
    end
  end

  assign irq = |(irq_stat_r & irq_en_r);

  // read data is captured in the setup cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      prdata <= 32'h0000_0000;
      if (tbl_sel)
        prdata <= {16'h0000, tbl[paddr[8:2]]};
      else if (paddr == wct_pkg::CTRL_OFS)
        prdata <= {17'h0_0000, count_r, 3'b000, indexed_r, op_r, rung_in_r};
      else if (paddr == wct_pkg::ADDR_OFS)
        prdata <= {9'h000, dst_r, 9'h000, src_r};
      else if (paddr == wct_pkg::OPER_OFS)
        prdata <= {opb_r, opa_r};
      else if (paddr == wct_pkg::STAT_OFS)
        prdata <= {27'h000_0000, rung_in_r, busy, error_flag, carry_flag, rung_out};
      else if (paddr == wct_pkg::ISTAT_OFS)
        prdata <= {30'h0000_0000, irq_stat_r};
      else if (paddr == wct_pkg::IEN_OFS)
        prdata <= {30'h0000_0000, irq_en_r};
    end
  end
endmodule : wct_unit
`default_nettype wire

/* verification/wct_unit_monitor.sv */
// checker of the word convert, test and shift unit
`timescale 1ns/100ps
`default_nettype none
module wct_unit_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic rung_out,
  input wire logic carry_flag,
  input wire logic error_flag
);
  logic cw;
  logic go;
  logic [2:0] op;
  logic [6:0] n;
  logic [31:0] opr_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  assign cw = psel && penable && pwrite && paddr == wct_pkg::CTRL_OFS;
  assign go = cw && pwdata[0] && n != 7'h00;
  assign op = pwdata[3:1];
  assign n = pwdata[14:8];
  // operand mirror; the shifts write back, so it follows those started with a nonzero count field
  always_ff @(posedge mclk)
  begin
    if (rst) opr_r <= 32'h0000_0000;
    else if (psel && penable && pwrite && paddr == wct_pkg::OPER_OFS) opr_r <= pwdata;
    else if (go && op == wct_pkg::shift_right_one_op) opr_r[15:0] <= opr_r[15:0] >> 1;
    else if (go && op == wct_pkg::shift_left_one_op) opr_r[15:0] <= opr_r[15:0] << 1;
  end
  property p_off;
    cw && !pwdata[0] |=> !rung_out;
  endproperty
  a_off: assert property (p_off) else $error("rung on");
  property p_err;
    error_flag && !(cw && pwdata[5]) |=> error_flag;
  endproperty
  a_err: assert property (p_err) else $error("error lost");
  property p_test;
    go && op == wct_pkg::bit_test_op |=> rung_out == |(opr_r[15:0] & opr_r[31:16]);
  endproperty
  a_test: assert property (p_test) else $error("bit test");
  property p_shr;
    go && op == wct_pkg::shift_right_one_op |=> carry_flag == $past(opr_r[0]) && rung_out == opr_r[0];
  endproperty
  a_shr: assert property (p_shr) else $error("right shift");
  property p_shl;
    go && op == wct_pkg::shift_left_one_op |=> carry_flag == $past(opr_r[15]) && rung_out == opr_r[15];
  endproperty
  a_shl: assert property (p_shl) else $error("left shift");
  property p_hidx;
    go && op == wct_pkg::hex_to_text_op && pwdata[4] && n != 7'h01 |=> error_flag && !rung_out;
  endproperty
  a_hidx: assert property (p_hidx) else $error("indexed count");
  property p_tidx;
    go && op == wct_pkg::text_to_hex_op && pwdata[4] && n != 7'h01 |=> error_flag && !rung_out;
  endproperty
  a_tidx: assert property (p_tidx) else $error("indexed count");
  property p_hcnt;
    go && op == wct_pkg::hex_to_text_op && n > wct_pkg::HTOT_MAX |=> error_flag && !rung_out;
  endproperty
  a_hcnt: assert property (p_hcnt) else $error("count range");
  c_ttoh: cover property (go && op == wct_pkg::text_to_hex_op);
  c_shl: cover property (go && op == wct_pkg::shift_left_one_op);
  c_err: cover property ($rose(error_flag));
endmodule : wct_unit_monitor
bind wct_unit wct_unit_monitor i_wct_unit_monitor (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rung_out(rung_out), .carry_flag(carry_flag),
  .error_flag(error_flag));
`default_nettype wire

/* verification/wct_seq_model.sv */
// behavioural scan sequencer: the apb master of the unit
`timescale 1ns/100ps
`default_nettype none
module wct_seq_model (
  input wire logic mclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0000_0000
);
  // request held until pready is sampled high or 16 edges pass; released after that edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e, output logic t);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    t = pready !== 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : wct_seq_model
`default_nettype wire

/* verification/wct_unit_tb.sv */
// self-checking bench of the word convert, test and shift unit
`timescale 1ns/100ps
`default_nettype none
module wct_unit_tb;
  typedef struct packed {logic [2:0] op; logic [31:0] opr; logic [15:0] res; logic [1:0] rc;} wct_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, rung_out, carry_flag, error_flag, irq, err, tmo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int miscompares = 0;
  int checked = 0;
  wct_row_t rows [6] = '{'{3'h2, 32'h0FFF_4008, 16'h4008, 2'b10}, '{3'h2, 32'h0FFF_F000, 16'hF000, 2'b00},
    '{3'h3, 32'h0000_0003, 16'h0001, 2'b11}, '{3'h3, 32'h0000_0004, 16'h0002, 2'b00},
    '{3'h4, 32'h0000_8000, 16'h0000, 2'b01}, '{3'h4, 32'h0000_4001, 16'h8002, 2'b10}};
  // op, indexed, count, error expected
  logic [11:0] bad [5] = '{12'h105, 12'h305, 12'h043, 12'h283, 12'h102};
  logic [7:0] chars [3] = '{8'h2F, 8'h3A, 8'h47};
  logic [15:0] txt [4] = '{16'h3130, 16'h4641, 16'h3332, 16'h4443};
  always #20 mclk = ~mclk;
  wct_unit i_wct_unit (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rung_out(rung_out),
    .carry_flag(carry_flag), .error_flag(error_flag), .irq(irq));
  wct_seq_model i_wct_seq_model (.mclk(mclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_wct_seq_model.xfer(w, a, d, rd, err, tmo);
    if (tmo)
    begin
      miscompares++;
      results();
    end
  endtask : bus
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdchk
  // polls busy under a bound, then lets the last edge's updates land
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      bus(1'b0, wct_pkg::STAT_OFS, 32'h0000_0000);
      n++;
    end
    while (rd[3] !== 1'b0 && n < 100);
    if (rd[3] !== 1'b0)
    begin
      miscompares++;
      results();
    end
    @(negedge mclk);
  endtask : wait_idle
  function automatic logic [31:0] ctl(input logic [2:0] op, input logic idx, input logic [6:0] n);
    return {17'h0_0000, n, 3'h0, idx, op, 1'b1};
  endfunction : ctl
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rdchk(wct_pkg::CTRL_OFS, 32'h0000_0100);
    rdchk(wct_pkg::STAT_OFS, 32'h0000_0000);
    foreach (rows[i])
    begin
      bus(1'b1, wct_pkg::OPER_OFS, rows[i].opr);
      bus(1'b1, wct_pkg::CTRL_OFS, ctl(rows[i].op, 1'b0, 7'h01));
      wait_idle();
      check({30'h0, rung_out, carry_flag}, {30'h0, rows[i].rc});
      rdchk(wct_pkg::OPER_OFS, {rows[i].opr[31:16], rows[i].res});
    end
    bus(1'b1, 12'h200, 32'h0000_01AF);
    bus(1'b1, 12'h204, 32'h0000_23CD);
    bus(1'b1, wct_pkg::ADDR_OFS, 32'h0008_0000);
    bus(1'b1, wct_pkg::CTRL_OFS, ctl(3'h0, 1'b0, 7'h02));
    wait_idle();
    check({31'h0, rung_out}, 32'h1);
    foreach (txt[k])
      rdchk(12'h220 + 12'(4 * k), {16'h0, txt[k]});
    // even count keeps the last packed word fully defined
    bus(1'b1, wct_pkg::ADDR_OFS, 32'h0010_0008);
    bus(1'b1, wct_pkg::CTRL_OFS, ctl(3'h1, 1'b0, 7'h04));
    wait_idle();
    rdchk(12'h240, 32'h0000_01AF);
    rdchk(12'h244, 32'h0000_23CD);
    bus(1'b1, wct_pkg::IEN_OFS, 32'h0000_0002);
    foreach (chars[k])
    begin
      bus(1'b1, wct_pkg::CTRL_OFS, 32'h0000_0120);
      bus(1'b1, wct_pkg::ICLR_OFS, 32'h0000_0003);
      bus(1'b1, 12'h220, {16'h0, chars[k], 8'h30});
      bus(1'b1, wct_pkg::CTRL_OFS, ctl(3'h1, 1'b0, 7'h04));
      wait_idle();
      check({29'h0, error_flag, rung_out, irq}, 32'h5);
      rdchk(12'h240, 32'h0000_01AF);
    end
    bus(1'b1, wct_pkg::IEN_OFS, 32'h0);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, wct_pkg::CTRL_OFS, 32'h0000_0120);
    bus(1'b1, wct_pkg::ICLR_OFS, 32'h0000_0003);
    rdchk(wct_pkg::ISTAT_OFS, 32'h0);
    foreach (bad[k])
    begin
      bus(1'b1, wct_pkg::CTRL_OFS, 32'h0000_0120);
      bus(1'b1, wct_pkg::CTRL_OFS, ctl(bad[k][11:9], bad[k][8], bad[k][7:1]));
      wait_idle();
      check({30'h0, error_flag, rung_out}, {30'h0, bad[k][0], !bad[k][0]});
    end
    bus(1'b1, wct_pkg::OPER_OFS, 32'h0000_0003);
    bus(1'b1, wct_pkg::CTRL_OFS, ctl(3'h3, 1'b0, 7'h01));
    bus(1'b1, wct_pkg::CTRL_OFS, 32'h0000_0106);
    wait_idle();
    check({30'h0, rung_out, carry_flag}, 32'h1);
    rdchk(wct_pkg::OPER_OFS, 32'h0000_0001);
    rdchk(wct_pkg::ISTAT_OFS, 32'h0000_0003);
    bus(1'b0, 12'h01C, 32'h0);
    check({31'h0, err}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    results();
  end
endmodule : wct_unit_tb
`default_nettype wire
